// ===== tmr_down_counter.sv
// 10-bit down-count timer with prescaler, reload modes and pwm output
module tmr_down_counter
   import tmr_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // register port
   input  wire tmr_bus_s   bus,
   output logic [7:0]      rdata,
   // external clock pin
   input  wire logic       extClockPin,
   // pwm pin and general io path
   input  wire logic       gpioOut,
   input  wire logic       gpioOe,
   output logic            pwmPinOut,
   output logic            pwmPinOe,
   // interrupt and status
   output logic            irq,
   output logic            underflowPulse
);
   logic [7:0] control1_r;
   logic [7:0] control2_r;
   logic [7:0] dutyLow_r;
   logic [7:0] highBits_r;
   logic [9:0] count_r;
   logic [9:0] count_nxt;
   logic [9:0] reload_r;
   logic       stopped_r;
   logic       stopped_nxt;
   logic [1:0] intStat_r;
   logic [1:0] intStat_nxt;
   logic [1:0] intMask_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       extSync1_r;
   logic       extSync2_r;
   logic       extLast_r;
   logic       pwmLevel_r;
   logic       underflow_r;

   logic       runEnable;
   logic       reloadSel;
   logic       oneShot;
   logic       pwmActiveLow;
   logic       pwmEnable;
   logic [2:0] prescaleRate;
   logic       prescalerDisable_n;
   logic       edgeSelect;
   logic       sourceSelect;
   logic       extRise;
   logic       extFall;
   logic       extTick;
   logic       srcTick;
   logic       countTick;
   logic       atZero;
   logic       underflowNow;
   logic       wrCount;
   logic       wrControl1;
   logic       wrControl2;
   logic       wrDuty;
   logic       wrHigh;
   logic       wrStatus;
   logic       wrMask;
   logic [9:0] writeValue;
   logic [9:0] dutyValue;
   logic       pwmActive;
   logic [7:0] preValue;
   logic [1:0] events;

   function automatic logic hit(input tmr_bus_s b, input logic [3:0] a);
      hit = b.wr && (b.addr == a);
   endfunction

   // field decode
   assign runEnable          = control1_r[RUN_BIT];
   assign reloadSel          = control1_r[RELOAD_BIT];
   assign oneShot            = control1_r[ONESHOT_BIT];
   assign pwmActiveLow       = control1_r[POL_BIT];
   assign pwmEnable          = control1_r[PWMEN_BIT];
   assign prescaleRate       = control2_r[2:0];
   assign prescalerDisable_n = control2_r[PSDIS_BIT];
   assign edgeSelect         = control2_r[EDGE_BIT];
   assign sourceSelect       = control2_r[SRC_BIT];

   // write decode
   assign wrCount    = hit(bus, ADDR_COUNT_LOW);
   assign wrControl1 = hit(bus, ADDR_CONTROL1);
   assign wrControl2 = hit(bus, ADDR_CONTROL2);
   assign wrDuty     = hit(bus, ADDR_DUTY_LOW);
   assign wrHigh     = hit(bus, ADDR_HIGH_BITS);
   assign wrStatus   = hit(bus, ADDR_INT_STATUS);
   assign wrMask     = hit(bus, ADDR_INT_MASK);
   assign writeValue = {highBits_r[HIGH_CNT_LO +: 2], bus.wdata};
   assign dutyValue  = {highBits_r[HIGH_DUTY_LO +: 2], dutyLow_r};

   // only the second stage and its delayed copy in extLast_r feed the edge compare
   assign extRise = extSync2_r && !extLast_r;
   assign extFall = !extSync2_r && extLast_r;
   assign extTick = edgeSelect ? extFall : extRise;
   // instruction clock is this clock, so it ticks every cycle
   assign srcTick = sourceSelect ? extTick : 1'b1;

   tmr_prescaler u_pre
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .tickIn   (srcTick),
      .rate     (prescaleRate),
      .bypass_n (prescalerDisable_n),
      .tickOut  (countTick),
      .preValue (preValue)
   );

   // count engine
   assign atZero       = (count_r == COUNT_ZERO);
   assign underflowNow = runEnable && countTick && atZero && !stopped_r
                         && !wrCount;

   always_comb
   begin
      count_nxt   = count_r;
      stopped_nxt = stopped_r;
      if (wrCount)
      begin
         count_nxt   = writeValue;
         stopped_nxt = 1'b0;
      end
      else if (runEnable && countTick && !stopped_r)
      begin
         if (!atZero)
            count_nxt = count_r - 10'h001;
         else if (oneShot)
            stopped_nxt = 1'b1;
         else if (reloadSel)
            count_nxt = reload_r;
         else
            count_nxt = COUNT_FULL;
      end
   end

   // events: bit0 underflow, bit1 pwm frame restart
   assign events      = {underflowNow && !oneShot, underflowNow};
   // set wins over a write-one clear in the same cycle
   assign intStat_nxt = (intStat_r & ~(wrStatus ? bus.wdata[1:0] : 2'b00))
                        | events;

   // pwm active while count is below duty
   assign pwmActive = (count_r < dutyValue);
   assign pwmPinOut = pwmEnable ? (pwmLevel_r ^ pwmActiveLow) : gpioOut;
   assign pwmPinOe  = pwmEnable ? 1'b1 : gpioOe;
   assign irq       = |(intStat_r & intMask_r);
   assign underflowPulse = underflow_r;

   // read mux; unmapped offsets read zero
   always_comb
   begin
      case (bus.addr)
         ADDR_COUNT_LOW:  rdata_nxt = count_r[7:0];
         ADDR_CONTROL1:   rdata_nxt = control1_r;
         ADDR_CONTROL2:   rdata_nxt = control2_r;
         ADDR_DUTY_LOW:   rdata_nxt = dutyLow_r;
         ADDR_HIGH_BITS:  rdata_nxt = highBits_r;
         ADDR_INT_STATUS: rdata_nxt = {6'b00_0000, intStat_r};
         ADDR_INT_MASK:   rdata_nxt = {6'b00_0000, intMask_r};
         default:         rdata_nxt = BYTE_ZERO;
      endcase
      if (!bus.rd)
         rdata_nxt = BYTE_ZERO;
   end
   assign rdata = rdata_r;

   always_ff @(posedge clk)
   begin
      extSync1_r <= extClockPin;
      extSync2_r <= extSync1_r;
      extLast_r  <= extSync2_r;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         control1_r <= CONTROL1_RESET;
         control2_r <= CONTROL2_RESET;
         dutyLow_r  <= BYTE_ZERO;
         highBits_r <= BYTE_ZERO;
         count_r    <= COUNT_FULL;
         reload_r   <= COUNT_FULL;
         stopped_r  <= 1'b0;
         intStat_r  <= 2'b00;
         intMask_r  <= 2'b00;
         rdata_r    <= BYTE_ZERO;
         pwmLevel_r <= 1'b0;
         underflow_r <= 1'b0;
      end
      else
      begin
         if (wrControl1)
            control1_r <= bus.wdata & CONTROL1_MASK;
         if (wrControl2)
            control2_r <= bus.wdata & CONTROL2_MASK;
         if (wrDuty)
            dutyLow_r <= bus.wdata;
         if (wrHigh)
            highBits_r <= bus.wdata;
         if (wrCount)
            reload_r <= writeValue;
         if (wrMask)
            intMask_r <= bus.wdata[1:0];
         count_r     <= count_nxt;
         stopped_r   <= stopped_nxt;
         intStat_r   <= intStat_nxt;
         rdata_r     <= rdata_nxt;
         pwmLevel_r  <= pwmActive;
         underflow_r <= underflowNow;
      end
   end

   // checks
   a_hold_when_off: assert property (@(posedge clk) disable iff (!rst_n)
      !runEnable && !wrCount |=> $stable(count_r))
      else $error("count moved while disabled");
   a_reload_full: assert property (@(posedge clk) disable iff (!rst_n)
      underflowNow && !oneShot && !reloadSel && !wrControl1
      |=> count_r == COUNT_FULL)
      else $error("no 0x3ff reload");
   a_reload_value: assert property (@(posedge clk) disable iff (!rst_n)
      underflowNow && !oneShot && reloadSel |=> count_r == $past(reload_r))
      else $error("reload value not taken");
   a_oneshot_stop: assert property (@(posedge clk) disable iff (!rst_n)
      underflowNow && oneShot |=> stopped_r && count_r == COUNT_ZERO)
      else $error("one-shot did not stop");
   a_count_load: assert property (@(posedge clk) disable iff (!rst_n)
      wrCount |=> count_r == $past(writeValue))
      else $error("count write lost");
   a_count_read: assert property (@(posedge clk) disable iff (!rst_n)
      bus.rd && bus.addr == ADDR_COUNT_LOW |=> rdata == $past(count_r[7:0]))
      else $error("count read wrong");
   a_pwm_pin: assert property (@(posedge clk) disable iff (!rst_n)
      pwmEnable |-> pwmPinOe && pwmPinOut == (pwmLevel_r ^ pwmActiveLow))
      else $error("pwm pin wrong");
   a_gpio_pass: assert property (@(posedge clk) disable iff (!rst_n)
      !pwmEnable |-> pwmPinOut == gpioOut && pwmPinOe == gpioOe)
      else $error("gpio not passed");
   a_ext_step: assert property (@(posedge clk) disable iff (!rst_n)
      sourceSelect && !extTick && !wrCount |=> $stable(count_r))
      else $error("counted without edge");
   a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
      underflowNow |=> intStat_r[0])
      else $error("underflow flag not set");
   a_bypass_tick: assert property (@(posedge clk) disable iff (!rst_n)
      prescalerDisable_n |-> countTick == srcTick)
      else $error("bypass not transparent");
   // a disabled prescaler must freeze, so a later enable starts cleanly
   a_pre_hold: assert property (@(posedge clk) disable iff (!rst_n)
      prescalerDisable_n |=> $stable(preValue))
      else $error("prescaler moved while off");
   c_underflow: cover property (@(posedge clk) underflowNow && reloadSel);
   c_oneshot: cover property (@(posedge clk) underflowNow && oneShot);
   c_ext_fall: cover property (@(posedge clk) sourceSelect && extFall);
   c_irq: cover property (@(posedge clk) irq);
endmodule

// ===== tmr_pkg.sv
// package: register map, field positions and types of the down-count timer
package tmr_pkg;
   localparam logic [3:0] ADDR_COUNT_LOW  = 4'h0;
   localparam logic [3:0] ADDR_CONTROL1   = 4'h1;
   localparam logic [3:0] ADDR_CONTROL2   = 4'h2;
   localparam logic [3:0] ADDR_DUTY_LOW   = 4'h3;
   localparam logic [3:0] ADDR_HIGH_BITS  = 4'h4;
   localparam logic [3:0] ADDR_INT_STATUS = 4'h5;
   localparam logic [3:0] ADDR_INT_MASK   = 4'h6;
   localparam logic [9:0] COUNT_FULL      = 10'h03FF;
   localparam logic [9:0] COUNT_ZERO      = 10'h0000;
   localparam logic [7:0] CONTROL1_RESET  = 8'h00;
   localparam logic [7:0] CONTROL2_RESET  = 8'h3F;
   localparam logic [7:0] CONTROL1_MASK   = 8'hC7;
   localparam logic [7:0] CONTROL2_MASK   = 8'h3F;
   localparam logic [7:0] BYTE_ZERO       = 8'h00;
   localparam logic [7:0] PRESCALE_RESET  = 8'hFF;
   localparam int RUN_BIT     = 0;
   localparam int RELOAD_BIT  = 1;
   localparam int ONESHOT_BIT = 2;
   localparam int POL_BIT     = 6;
   localparam int PWMEN_BIT   = 7;
   localparam int PSDIS_BIT   = 3;
   localparam int EDGE_BIT    = 4;
   localparam int SRC_BIT     = 5;
   localparam int HIGH_CNT_LO = 4;
   localparam int HIGH_DUTY_LO = 0;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tmr_bus_s;
endpackage

// ===== tmr_prescaler.sv
// prescaler: free counter with power-of-two tap select
module tmr_prescaler
   import tmr_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // tick in, rate, bypass
   input  wire logic       tickIn,
   input  wire logic [2:0] rate,
   input  wire logic       bypass_n,
   // divided tick
   output logic            tickOut,
   output logic [7:0]      preValue
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic       tapHit;
   logic [7:0] tapMask;

   // counts down from all ones; preValue brings the count out
   assign cnt_nxt = (tickIn && !bypass_n) ? cnt_r - 8'h01 : cnt_r;
   // rate n divides by 2^(n+1): tap bits 0..n all zero before the step
   assign tapMask = 8'(({1'b0, 8'h00} | 9'h001) << ({1'b0, rate} + 4'h1))
                    - 8'h01;
   assign tapHit  = ((cnt_r & tapMask) == BYTE_ZERO);
   // bypass passes every tick straight through
   assign tickOut = bypass_n ? tickIn : (tickIn && tapHit);
   assign preValue = cnt_r;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cnt_r <= PRESCALE_RESET;
      else
         cnt_r <= cnt_nxt;
   end
endmodule

// ===== tmr_down_counter_tb.sv
// self-checking bench for the down-count timer
module tmr_down_counter_tb
   import tmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clk;
   logic       rst_n;
   tmr_bus_s   bus;
   logic [7:0] rdata;
   logic       extClockPin;
   logic       gpioOut;
   logic       gpioOe;
   logic       pwmPinOut;
   logic       pwmPinOe;
   logic       irq;
   logic       underflowPulse;
   int         miscompares;
   int         compares;
   int         cycles;
   int         n;

   tmr_down_counter dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .extClockPin(extClockPin), .gpioOut(gpioOut), .gpioOe(gpioOe),
      .pwmPinOut(pwmPinOut), .pwmPinOe(pwmPinOe), .irq(irq),
      .underflowPulse(underflowPulse));

   task automatic summarize();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
      #1;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp,
                        input string nm);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      chk(nm, 16'(rdata), 16'(exp));
   endtask

   task automatic waitc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   // cycles from one underflow pulse to the next, bounded
   task automatic per(output int p);
      int k = 0;
      while (underflowPulse !== 1'b1 && k < 3000)
      begin
         waitc(1);
         k++;
      end
      p = 0;
      do
      begin
         waitc(1);
         p++;
      end
      while (underflowPulse !== 1'b1 && p < 3000);
   endtask

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         miscompares++;
         summarize();
      end
   end

   initial
   begin
      rst_n = 1'b0;
      bus = '{addr: 4'h0, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
      extClockPin = 1'b1;
      gpioOut = 1'b1;
      gpioOe = 1'b0;
      miscompares = 0;
      compares = 0;
      cycles = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(ADDR_CONTROL1, 8'h00, "control_one");
      rdchk(ADDR_CONTROL2, 8'h3F, "control_two");
      rdchk(ADDR_COUNT_LOW, 8'hFF, "count_low");
      rdchk(ADDR_INT_STATUS, 8'h00, "status");
      rdchk(4'hF, 8'h00, "unmapped");
      chk("pinOe", 16'(pwmPinOe), 16'h0000);
      chk("pinOut", 16'(pwmPinOut), 16'h0001);
      $display("test reset done");
      // prescaler off and instruction clock before any load
      wr(ADDR_CONTROL2, 8'h08);
      wr(ADDR_HIGH_BITS, 8'h10);
      wr(ADDR_COUNT_LOW, 8'h34);
      wr(4'hF, 8'h55);
      rdchk(ADDR_COUNT_LOW, 8'h34, "count_held");
      rdchk(ADDR_COUNT_LOW, 8'h34, "count_halt");
      rdchk(4'hF, 8'h00, "unmapped_wr");
      $display("test load and halt done");
      wr(ADDR_CONTROL1, 8'h03);
      per(n);
      per(n);
      chk("reload_period", 16'(n), 16'h0135);
      wr(ADDR_CONTROL1, 8'h01);
      per(n);
      per(n);
      chk("full_period", 16'(n), 16'h0400);
      $display("test reload modes done");
      wr(ADDR_CONTROL1, 8'h00);
      rdchk(ADDR_INT_STATUS, 8'h03, "status_both");
      wr(ADDR_INT_STATUS, 8'h03);
      wr(ADDR_HIGH_BITS, 8'h00);
      wr(ADDR_COUNT_LOW, 8'h05);
      wr(ADDR_CONTROL1, 8'h07);
      waitc(20);
      rdchk(ADDR_COUNT_LOW, 8'h00, "oneshot_stop");
      rdchk(ADDR_INT_STATUS, 8'h01, "status_set");
      chk("irq_masked", 16'(irq), 16'h0000);
      wr(ADDR_INT_MASK, 8'h01);
      chk("irq_on", 16'(irq), 16'h0001);
      wr(ADDR_INT_STATUS, 8'h01);
      chk("irq_clear", 16'(irq), 16'h0000);
      rdchk(ADDR_INT_STATUS, 8'h00, "status_clr");
      $display("test one-shot and interrupt done");
      wr(ADDR_CONTROL1, 8'h00);
      wr(ADDR_COUNT_LOW, 8'h03);
      wr(ADDR_CONTROL1, 8'h03);
      for (int r = 0; r < 8; r++)
      begin
         wr(ADDR_CONTROL2, 8'(8'h08 | r));
         wr(ADDR_CONTROL2, 8'(r));
         per(n);
         per(n);
         chk("prescale_period", 16'(n), 16'(4 << (r + 1)));
      end
      $display("test prescaler done");
      wr(ADDR_CONTROL1, 8'h00);
      wr(ADDR_CONTROL2, 8'h28);
      wr(ADDR_COUNT_LOW, 8'h05);
      wr(ADDR_CONTROL1, 8'h01);
      waitc(8);
      rdchk(ADDR_COUNT_LOW, 8'h05, "ext_idle");
      @(posedge clk);
      extClockPin <= 1'b0;
      waitc(8);
      rdchk(ADDR_COUNT_LOW, 8'h05, "ext_fall_ign");
      @(posedge clk);
      extClockPin <= 1'b1;
      waitc(8);
      rdchk(ADDR_COUNT_LOW, 8'h04, "ext_rise");
      wr(ADDR_CONTROL2, 8'h38);
      @(posedge clk);
      extClockPin <= 1'b0;
      waitc(8);
      rdchk(ADDR_COUNT_LOW, 8'h03, "ext_fall");
      @(posedge clk);
      extClockPin <= 1'b1;
      waitc(8);
      rdchk(ADDR_COUNT_LOW, 8'h03, "ext_rise_ign");
      $display("test external clock done");
      wr(ADDR_CONTROL1, 8'h00);
      wr(ADDR_COUNT_LOW, 8'h05);
      wr(ADDR_DUTY_LOW, 8'h10);
      wr(ADDR_CONTROL1, 8'h80);
      waitc(2);
      chk("pwm_oe", 16'(pwmPinOe), 16'h0001);
      chk("pwm_high", 16'(pwmPinOut), 16'h0001);
      wr(ADDR_CONTROL1, 8'hC0);
      waitc(2);
      chk("pwm_low", 16'(pwmPinOut), 16'h0000);
      rdchk(ADDR_CONTROL1, 8'hC0, "control_rb");
      wr(ADDR_DUTY_LOW, 8'h02);
      waitc(2);
      chk("pwm_idle", 16'(pwmPinOut), 16'h0001);
      wr(ADDR_CONTROL1, 8'h00);
      waitc(1);
      chk("gpio_oe", 16'(pwmPinOe), 16'h0000);
      chk("gpio_out", 16'(pwmPinOut), 16'h0001);
      @(posedge clk);
      gpioOut <= 1'b0;
      gpioOe  <= 1'b1;
      #1;
      chk("gpio_low", 16'(pwmPinOut), 16'h0000);
      chk("gpio_drive", 16'(pwmPinOe), 16'h0001);
      $display("test pwm pin done");
      summarize();
   end
endmodule
